// [pcrc_fifo_mem.sv]
// constants shared by the crc generator, and its fifo word store
// assumes one clock, pclk, and a single writer and single reader
package pcrc_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL_ONE = 12'h000;
   localparam logic [11:0] OFS_CTRL_TWO = 12'h004;
   localparam logic [11:0] OFS_TAPS_HIGH = 12'h008;
   localparam logic [11:0] OFS_TAPS_LOW = 12'h00c;
   localparam logic [11:0] OFS_DATA_IN = 12'h010;
   localparam logic [11:0] OFS_RESULT = 12'h014;
   localparam int unsigned BIT_ENABLE = 15;
   localparam int unsigned BIT_STOP_IDLE = 13;
   localparam int unsigned CNT_LSB = 8;
   localparam int unsigned CNT_MSB = 12;
   localparam int unsigned BIT_FULL = 7;
   localparam int unsigned BIT_EMPTY = 6;
   localparam int unsigned BIT_IRQ_SEL = 5;
   localparam int unsigned BIT_RUN = 4;
   localparam int unsigned BIT_LSB_FIRST = 3;
   localparam int unsigned DW_LSB = 8;
   localparam int unsigned DW_MSB = 12;
   localparam int unsigned PL_LSB = 0;
   localparam int unsigned PL_MSB = 4;
   localparam logic [15:0] TAPS_LOW_MASK = 16'hfffe;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned MEM_DEPTH = 16;
   localparam int unsigned PTR_W = 4;
   localparam logic [4:0] DEPTH_SHORT = 5'h10;
   localparam logic [4:0] DEPTH_LONG = 5'h08;
   localparam logic [4:0] PLEN_DEPTH_LIMIT = 5'h07;
   typedef enum logic [1:0] {
      PCRC_IDLE = 2'b00,
      PCRC_FETCH = 2'b01,
      PCRC_SHIFT = 2'b10
   } pcrc_state_t;
endpackage

`timescale 1ns/1ps
module pcrc_fifo_mem (
   input wire logic pclk,
   input wire logic wr_en,
   input wire logic [pcrc_pkg::PTR_W-1:0] wr_addr,
   input wire logic [pcrc_pkg::WORD_W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [pcrc_pkg::PTR_W-1:0] rd_addr,
   output logic [pcrc_pkg::WORD_W-1:0] rd_data
);
   import pcrc_pkg::*;
   // no reset on storage; contents only matter once counted valid
   logic [WORD_W-1:0] mem_reg [MEM_DEPTH];

   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // read data held until the next read
   always_ff @(posedge pclk) begin
      if (rd_en) begin
         rd_data <= mem_reg[rd_addr];
      end
   end
endmodule // pcrc_fifo_mem

// [pcrc_top.sv]
// programmable crc generator with apb register port and data fifo
// assumes apb master on pclk; sys_idle high while the system idles
`timescale 1ns/1ps

module pcrc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pcrc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sys_idle,
   output logic crc_irq
);
   import pcrc_pkg::*;

   function automatic logic [4:0] fifo_depth(input logic [4:0] plen);
      fifo_depth = (plen > PLEN_DEPTH_LIMIT) ? DEPTH_LONG : DEPTH_SHORT;
   endfunction

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p,
                                                input logic [4:0] depth);
      logic [4:0] wide;
      wide = {1'b0, p} + 5'h01;
      ptr_inc = (wide == depth) ? '0 : wide[PTR_W-1:0];
   endfunction

   logic enable_reg;
   logic stop_idle_reg;
   logic irq_sel_reg;
   logic run_reg;
   logic lsb_first_reg;
   logic [4:0] dwidth_reg;
   logic [4:0] plen_reg;
   logic [15:0] taps_high_reg;
   logic [15:0] taps_low_reg;
   logic [31:0] crc_reg;
   logic [31:0] crc_next;
   logic [4:0] count_reg;
   logic [4:0] count_next;
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [4:0] bit_cnt_reg;
   logic irq_reg;
   pcrc_state_t state_reg;
   pcrc_state_t state_next;
   logic [31:0] prdata_reg;
   logic [WORD_W-1:0] word_data;

   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable;
   wire wr_acc = access_ph & pwrite;
   wire hit_c1 = (paddr == OFS_CTRL_ONE);
   wire hit_c2 = (paddr == OFS_CTRL_TWO);
   wire hit_th = (paddr == OFS_TAPS_HIGH);
   wire hit_tl = (paddr == OFS_TAPS_LOW);
   wire hit_di = (paddr == OFS_DATA_IN);
   wire hit_rs = (paddr == OFS_RESULT);
   wire mapped = hit_c1 | hit_c2 | hit_th | hit_tl | hit_di | hit_rs;

   wire [4:0] depth = fifo_depth(plen_reg);
   wire full_flag = (count_reg >= depth);
   wire empty_flag = (count_reg == 5'h00);

   wire suspended = stop_idle_reg & sys_idle;
   wire active = enable_reg & run_reg & ~suspended;

   wire push = wr_acc & hit_di & enable_reg & ~full_flag;
   wire pop = active & (state_reg == PCRC_FETCH);
   wire last_bit = (bit_cnt_reg == dwidth_reg);
   wire shift_step = active & (state_reg == PCRC_SHIFT);
   wire word_done = shift_step & last_bit;
   // seed load only while no word is in flight
   wire seed_wr = wr_acc & hit_rs & enable_reg & (state_reg == PCRC_IDLE);

   wire [4:0] bit_idx = lsb_first_reg ? bit_cnt_reg : (dwidth_reg - bit_cnt_reg);
   wire data_bit = word_data[bit_idx];

   wire [31:0] taps_all = {taps_high_reg, taps_low_reg};
   wire [31:0] len_mask = 32'hffffffff >> (5'h1f - plen_reg);
   wire top_bit = crc_reg[plen_reg];
   wire feedback = data_bit ^ top_bit;
   wire [31:0] poly = (taps_all | 32'h00000001) & len_mask;
   wire [31:0] crc_stepped = ({crc_reg[30:0], 1'b0} & len_mask) ^ (feedback ? poly : '0);

   always_comb begin
      crc_next = crc_reg;
      if (seed_wr) begin
         crc_next = pwdata & len_mask;
      end else if (shift_step) begin
         crc_next = crc_stepped;
      end
   end

   always_comb begin
      count_next = count_reg;
      if (push & ~pop) begin
         count_next = count_reg + 5'h01;
      end else if (pop & ~push) begin
         count_next = count_reg - 5'h01;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PCRC_IDLE: begin
            if (active & ~empty_flag) begin
               state_next = PCRC_FETCH;
            end
         end
         PCRC_FETCH: begin
            if (active) begin
               state_next = PCRC_SHIFT;
            end
         end
         PCRC_SHIFT: begin
            if (word_done) begin
               state_next = empty_flag ? PCRC_IDLE : PCRC_FETCH;
            end
         end
         // illegal code recovers to idle
         default: begin
            state_next = PCRC_IDLE;
         end
      endcase
   end

   wire irq_fire = irq_sel_reg ? (pop & (count_next == 5'h00))
                               : (word_done & empty_flag);

   pcrc_fifo_mem u_mem (
      .pclk(pclk),
      .wr_en(push),
      .wr_addr(wr_ptr_reg),
      .wr_data(pwdata),
      .rd_en(pop),
      .rd_addr(rd_ptr_reg),
      .rd_data(word_data)
   );

   // control registers survive a disable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= 1'b0;
         stop_idle_reg <= 1'b0;
         irq_sel_reg <= 1'b0;
         run_reg <= 1'b0;
         lsb_first_reg <= 1'b0;
      end else if (wr_acc & hit_c1) begin
         enable_reg <= pwdata[BIT_ENABLE];
         stop_idle_reg <= pwdata[BIT_STOP_IDLE];
         irq_sel_reg <= pwdata[BIT_IRQ_SEL];
         run_reg <= pwdata[BIT_RUN];
         lsb_first_reg <= pwdata[BIT_LSB_FIRST];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dwidth_reg <= '0;
         plen_reg <= '0;
         taps_high_reg <= '0;
         taps_low_reg <= '0;
      end else begin
         if (wr_acc & hit_c2) begin
            dwidth_reg <= pwdata[DW_MSB:DW_LSB];
            plen_reg <= pwdata[PL_MSB:PL_LSB];
         end
         if (wr_acc & hit_th) begin
            taps_high_reg <= pwdata[15:0];
         end
         if (wr_acc & hit_tl) begin
            taps_low_reg <= pwdata[15:0] & TAPS_LOW_MASK;
         end
      end
   end

   wire engine_clr = ~enable_reg;
   wire [PTR_W-1:0] wr_ptr_next = push ? ptr_inc(wr_ptr_reg, depth) : wr_ptr_reg;
   wire [PTR_W-1:0] rd_ptr_next = pop ? ptr_inc(rd_ptr_reg, depth) : rd_ptr_reg;
   wire bit_step = shift_step & ~last_bit;
   wire [4:0] bit_cnt_next = pop ? 5'h00 : (bit_step ? bit_cnt_reg + 5'h01 : bit_cnt_reg);

   // one short block per register, the two fifo pointers sharing one; clear loads the reset constants
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= PCRC_IDLE;
      end else if (engine_clr) begin
         state_reg <= PCRC_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else if (engine_clr) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_reg <= '0;
      end else if (engine_clr) begin
         crc_reg <= '0;
      end else begin
         crc_reg <= crc_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else if (engine_clr) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_fire;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (engine_clr) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_reg <= '0;
      end else if (engine_clr) begin
         bit_cnt_reg <= '0;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   // read data captured in setup so access phase needs no wait
   wire [15:0] c1_view = {enable_reg, 1'b0, stop_idle_reg, count_reg,
                          full_flag, empty_flag, irq_sel_reg, run_reg,
                          lsb_first_reg, 3'h0};
   wire [31:0] rd_mux = hit_c1 ? {16'h0000, c1_view} :
                        hit_c2 ? {19'h0, dwidth_reg, 3'h0, plen_reg} :
                        hit_th ? {16'h0000, taps_high_reg} :
                        hit_tl ? {16'h0000, taps_low_reg} :
                        hit_rs ? crc_reg : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (setup_ph & ~pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = access_ph & ~mapped;
   assign crc_irq = irq_reg;
endmodule // pcrc_top

// [pcrc_monitor.sv]
// port checker for the crc generator
// assumes bound onto pcrc_top; one pclk domain
`timescale 1ns/1ps
module pcrc_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pcrc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic crc_irq
);
   import pcrc_pkg::*;
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   wire mapped = paddr inside {OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_TAPS_HIGH, OFS_TAPS_LOW,
      OFS_DATA_IN, OFS_RESULT};
   logic [4:0] plen_reg;
   logic en_reg;
   // shadow of length and enable, so read values can be judged
   wire [4:0] depth = (plen_reg > PLEN_DEPTH_LIMIT) ? DEPTH_LONG : DEPTH_SHORT;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         plen_reg <= 5'h00;
         en_reg <= 1'b0;
      end else if (acc && pwrite && paddr == OFS_CTRL_TWO) begin
         plen_reg <= pwdata[4:0];
      end else if (acc && pwrite && paddr == OFS_CTRL_ONE) begin
         en_reg <= pwdata[BIT_ENABLE];
      end
   end
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   property p_err; acc |-> pslverr == !mapped; endproperty
   a_err: assert property (p_err) else $error("bad error flag");
   property p_pulse; crc_irq |=> !crc_irq; endproperty
   a_pulse: assert property (p_pulse) else $error("irq too long");
   property p_c1; rd && paddr == OFS_CTRL_ONE |-> (prdata & ~32'h0000bff8) == 32'h0; endproperty
   a_c1: assert property (p_c1) else $error("ctrl1 spare bits");
   property p_c2; rd && paddr == OFS_CTRL_TWO |-> (prdata & ~32'h00001f1f) == 32'h0; endproperty
   a_c2: assert property (p_c2) else $error("ctrl2 spare bits");
   property p_taps; rd && paddr == OFS_TAPS_LOW |-> prdata[0] == 1'b0; endproperty
   a_taps: assert property (p_taps) else $error("tap bit0 set");
   property p_flags; rd && paddr == OFS_CTRL_ONE |-> prdata[6] == (prdata[12:8] == 5'h00)
      && prdata[7] == (prdata[12:8] >= depth); endproperty
   a_flags: assert property (p_flags) else $error("fifo flags");
   property p_width; rd && paddr == OFS_RESULT |-> (prdata >> plen_reg) <= 32'h1; endproperty
   a_width: assert property (p_width) else $error("result too wide");
   property p_off; rd && paddr == OFS_CTRL_ONE && !en_reg && !$past(en_reg)
      |-> prdata[12:6] == 7'h01; endproperty
   a_off: assert property (p_off) else $error("fifo kept while off");
   property p_irq_off; !en_reg && !$past(en_reg) |-> !crc_irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while off");
   property p_rd_zero; rd && (paddr == OFS_DATA_IN || !mapped) |-> prdata == 32'h0; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("write-only read not zero");
endmodule // pcrc_monitor
bind pcrc_top pcrc_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .crc_irq);

// [pcrc_top_tb.sv]
// bench for the crc generator: apb tasks, crc cases, fifo fill
// assumes an apb slave on pclk and a one-cycle irq pulse
`timescale 1ns/1ps
module pcrc_top_tb;
   import pcrc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sys_idle = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, ex;
   logic pready, pslverr, crc_irq, err;
   int error_cnt = 0, num_checks = 0, irq_cnt = 0, dep;
   logic [4:0] c_pl [4] = '{5'h0f, 5'h1f, 5'h07, 5'h04};
   logic [4:0] c_dw [4] = '{5'h07, 5'h1f, 5'h0f, 5'h04};
   logic [31:0] c_tp [4] = '{32'h1021, 32'h04c11db7, 32'h7, 32'h5};
   logic [31:0] c_dt [4] = '{32'h31, 32'h12345678, 32'habcd, 32'h15};
   logic [7:0] c_md [4] = '{8'h10, 8'h18, 8'h30, 8'h38};
   pcrc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sys_idle, .crc_irq);
   initial begin
      forever #10 pclk = ~pclk;
   end
   // counted off the edge, the pulse lands on it
   always @(negedge pclk) begin
      if (crc_irq === 1'b1) irq_cnt++;
   end
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no local limit: the watchdog ends a hung wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   task automatic wait_irq(input int k);
      int n;
      n = 0;
      while (irq_cnt < k && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk("irqs", k, irq_cnt);
   endtask
   function automatic logic [31:0] crc_f(logic [31:0] c, logic [31:0] d, int w, int n,
      logic [31:0] t, logic lsb);
      logic [31:0] m;
      logic fb;
      m = (n == 32) ? 32'hffffffff : (32'h1 << n) - 32'h1;
      for (int i = 0; i < w; i++) begin
         fb = (lsb ? d[i] : d[w-1-i]) ^ c[n-1];
         c = ((c << 1) & m) ^ (fb ? ((t | 32'h1) & m) : 32'h0);
      end
      return c;
   endfunction
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rc(OFS_CTRL_ONE, 32'h40);
      wr(OFS_CTRL_TWO, '1);
      rc(OFS_CTRL_TWO, 32'h1f1f);
      wr(OFS_TAPS_LOW, '1);
      rc(OFS_TAPS_LOW, 32'hfffe);
      wr(OFS_TAPS_HIGH, '1);
      rc(OFS_TAPS_HIGH, 32'hffff);
      wr(OFS_CTRL_ONE, '1);
      rc(OFS_CTRL_ONE, 32'ha078);
      wr(OFS_RESULT, 32'h89abcdef);
      rc(OFS_RESULT, 32'h89abcdef);
      rc(12'h040, 32'h0);
      chk("slverr", 32'h1, err);
      rc(OFS_DATA_IN, 32'h0);
      wr(OFS_CTRL_ONE, 32'h0);
      rc(OFS_CTRL_TWO, 32'h1f1f);
      sys_idle <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         ex = crc_f(32'h0, c_dt[k], c_dw[k] + 1, c_pl[k] + 1, c_tp[k], c_md[k][3]);
         ex = crc_f(ex, ~c_dt[k], c_dw[k] + 1, c_pl[k] + 1, c_tp[k], c_md[k][3]);
         wr(OFS_CTRL_ONE, 32'h0);
         wr(OFS_CTRL_TWO, {19'h0, c_dw[k], 3'h0, c_pl[k]});
         wr(OFS_TAPS_HIGH, c_tp[k] >> 16);
         wr(OFS_TAPS_LOW, c_tp[k] & 32'hffff);
         irq_cnt = 0;
         wr(OFS_CTRL_ONE, {16'h0, 8'h80, c_md[k]});
         wr(OFS_DATA_IN, c_dt[k]);
         wr(OFS_DATA_IN, ~c_dt[k]);
         wait_irq(c_md[k][5] + 1);
         if (c_md[k][5] == 1'b0) rc(OFS_RESULT, ex);
         repeat (40) @(posedge pclk);
         chk("irqs", c_md[k][5] + 1, irq_cnt);
         rc(OFS_RESULT, ex);
      end
      wr(OFS_TAPS_HIGH, 32'h0);
      wr(OFS_TAPS_LOW, 32'h3);
      // overfill with shifter off, then drain in order
      for (int j = 0; j < 2; j++) begin
         dep = j ? 8 : 16;
         wr(OFS_CTRL_ONE, 32'h0);
         wr(OFS_CTRL_TWO, j ? 32'h030f : 32'h0303);
         wr(OFS_CTRL_ONE, 32'h8000);
         ex = 0;
         for (int i = 0; i <= dep; i++) begin
            wr(OFS_DATA_IN, i);
            if (i < dep) ex = crc_f(ex, i, 4, j ? 16 : 4, 32'h3, 1'b0);
         end
         rc(OFS_CTRL_ONE, 32'h8080 | (dep << 8));
         wr(OFS_CTRL_ONE, 32'ha010);
         repeat (40) @(posedge pclk);
         rc(OFS_CTRL_ONE, 32'ha090 | (dep << 8));
         irq_cnt = 0;
         sys_idle <= 1'b0;
         wait_irq(1);
         rc(OFS_RESULT, ex);
         rc(OFS_CTRL_ONE, 32'ha050);
         sys_idle <= 1'b1;
      end
      wr(OFS_DATA_IN, 32'h5);
      rc(OFS_CTRL_ONE, 32'ha110);
      wr(OFS_CTRL_ONE, 32'h0);
      wr(OFS_DATA_IN, 32'h5);
      rc(OFS_CTRL_ONE, 32'h40);
      rc(OFS_RESULT, 32'h0);
      rc(OFS_TAPS_LOW, 32'h2);
      complete_run;
   end
   initial begin
      #400000;
      error_cnt++;
      complete_run;
   end
endmodule // pcrc_top_tb
